// ===== mpt_pkg.sv
package mpt_pkg;

	localparam int MPT_CLK_PERIOD_NS = 25;
	localparam int MPT_SECOND_NS = 1000000000;
	localparam int MPT_SECOND_CYCLES = MPT_SECOND_NS / MPT_CLK_PERIOD_NS;

	localparam int MPT_NCHK = 10;
	localparam int MPT_DLY_W = 8;

	// Check slots, lower index wins a same-cycle tie
	localparam int MPT_CHK_VIMB = 0;
	localparam int MPT_CHK_OV = 1;
	localparam int MPT_CHK_UVSTART = 2;
	localparam int MPT_CHK_UVRUN = 3;
	localparam int MPT_CHK_SHORTED = 4;
	localparam int MPT_CHK_SHUNT = 5;
	localparam int MPT_CHK_IIMB = 6;
	localparam int MPT_CHK_OC = 7;
	localparam int MPT_CHK_UC = 8;
	localparam int MPT_CHK_GF = 9;

	// Fault code is slot plus one, zero means no fault
	localparam logic [3:0] MPT_FAULT_NONE = 4'h0;

	localparam logic [11:0] MPT_PCT_BASE = 12'h064;

	// Factory delays in seconds, loaded by the parameter store
	localparam logic [7:0] MPT_DEF_VIMB_DLY = 8'h0A;
	localparam logic [7:0] MPT_DEF_OV_DLY = 8'h0A;
	localparam logic [7:0] MPT_DEF_UVSTART_DLY = 8'h0A;
	localparam logic [7:0] MPT_DEF_UVRUN_DLY = 8'h02;
	localparam logic [7:0] MPT_DEF_SHORTED_DLY = 8'h01;
	localparam logic [7:0] MPT_DEF_SHUNT_DLY = 8'h01;
	localparam logic [7:0] MPT_DEF_IIMB_DLY = 8'h02;
	localparam logic [7:0] MPT_DEF_OC_DLY = 8'h01;
	localparam logic [7:0] MPT_DEF_UC_DLY = 8'h02;
	localparam logic [7:0] MPT_DEF_GF_DLY = 8'h02;

	typedef enum logic [1:0] {
		MPT_MOTOR_OFF,
		MPT_MOTOR_STARTING,
		MPT_MOTOR_AT_SPEED
	} mpt_motor_state_t;

	typedef struct packed {
		logic [9:0] nominalLineVoltage;
		logic [7:0] voltageImbalanceThreshold;
		logic [7:0] voltageImbalanceDelay;
		logic [7:0] overvoltageThreshold;
		logic [7:0] overvoltageDelay;
		logic [7:0] startUndervoltageThreshold;
		logic [7:0] startUndervoltageDelay;
		logic [7:0] runUndervoltageThreshold;
		logic [7:0] runUndervoltageDelay;
		logic [7:0] shortedThyristorDelay;
		logic [7:0] offStateCurrentDelay;
		logic [7:0] currentImbalanceThreshold;
		logic [7:0] currentImbalanceDelay;
		logic [8:0] overcurrentThreshold;
		logic [7:0] overcurrentDelay;
		logic [7:0] undercurrentThreshold;
		logic [7:0] undercurrentDelay;
		logic [7:0] groundFaultThreshold;
		logic [7:0] groundFaultDelay;
		logic [11:0] currentTransformerValue;
		logic [11:0] motorFullLoadCurrent;
	} mpt_settings_t;

	typedef struct packed {
		logic [9:0] lineVoltageAB;
		logic [9:0] lineVoltageBC;
		logic [9:0] lineVoltageCA;
		logic [11:0] currentA;
		logic [11:0] currentB;
		logic [11:0] currentC;
		logic [11:0] groundCurrent;
	} mpt_meas_t;

endpackage

// ===== mpt_qualify_timer.sv
`timescale 1ns/1ps
module mpt_qualify_timer #(
	parameter int DLY_W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic secTick,
	input wire logic faultCond,
	input wire logic [DLY_W-1:0] delaySec,
	output logic qualified
);

	logic [DLY_W:0] count_reg;
	logic qualified_reg;

	// Counts whole seconds of a continuous condition
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_reg <= '0;
		end else if (!faultCond) begin
			count_reg <= '0;
		end else if (secTick && count_reg != '1) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// Strictly more than the delay; first tick may be a partial second
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			qualified_reg <= 1'b0;
		end else begin
			qualified_reg <= faultCond && delaySec != '0
				&& count_reg > {1'b0, delaySec};
		end
	end

	assign qualified = qualified_reg;

endmodule

// ===== mpt_trip_logic.sv
`timescale 1ns/1ps
// Function
// - Trip when any line voltage exceeds nominal by the set percent; zero disables.
// - Over-voltage delay is 1 to 20 seconds, factory 10.
// - While starting, trip on line voltage below nominal by set percent; zero disables.
// - Start under-voltage delay is 1 to 180 seconds, factory 10.
// - At speed, use the run under-voltage percent; ignore it while starting.
// - Run under-voltage trips on deficit equal or above setting; delay 1-20 s, factory 2.
// - All voltage checks run together; the first to qualify trips.
// - Current percents scale to full-load current; ground fault scales to CT value.
// - Trip after shorted thyristor delay 1 to 10 s, factory 1; zero disables.
// - Current while off raises a shunt trip after 1-10 s; zero disables.
// - Current imbalance 5-30 percent trips after 1-20 s, factory 2; zero disables.
// - Over-current trips when any phase exceeds 100-300 percent; zero disables.
// - Over-current delay is 1 to 20 seconds, factory 1.
// - Over-current is armed only at speed, never during acceleration.
// - Under-current trips when any phase is below 10-90 percent; zero disables.
// - Under-current delay is 1 to 60 seconds, factory 2.
// - Ground current above 5-90 percent of CT value trips; zero disables.
// - Ground fault delay is 1 to 60 seconds, factory 2.
// - Lockout time comes from the real-time clock and survives power loss.
// - Three-wire start does not latch in lockout; a fresh start is needed.
// - Two-wire maintained start may restart alone once the lockout ends.
// - A user function clears all active lockouts immediately.
// - Trip when any phase deviates from average voltage by 1-30 percent.
// - Voltage imbalance delay is 1 to 20 seconds, factory 10.
module mpt_trip_logic
	import mpt_pkg::*;
#(
	parameter int SECOND_CYCLES = MPT_SECOND_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input mpt_pkg::mpt_settings_t settings,
	input mpt_pkg::mpt_meas_t meas,
	input mpt_pkg::mpt_motor_state_t motorState,
	input wire logic shortedThyristorDetected,
	input wire logic startCmd,
	input wire logic stopCmd,
	input wire logic threeWireControl,
	input wire logic faultReset,
	input wire logic lockoutClearFunction,
	input wire logic [11:0] lockoutRemainingSec,
	output logic runRequest,
	output logic tripActive,
	output logic [3:0] faultCode,
	output logic [MPT_NCHK-1:0] qualifiedFlags,
	output logic lockoutBlocking,
	output logic lockoutClearPulse
);
	import mpt_pkg::*;

	typedef enum logic {
		MPT_RUN_IDLE,
		MPT_RUN_ON
	} mpt_run_state_t;

	function automatic logic [23:0] mul(input logic [11:0] a, input logic [11:0] b);
		mul = 24'(a) * 24'(b);
	endfunction

	function automatic logic [11:0] absDiff(input logic [11:0] a, input logic [11:0] b);
		absDiff = (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [3:0] firstCode(input logic [MPT_NCHK-1:0] flags);
		firstCode = MPT_FAULT_NONE;
		for (int k = MPT_NCHK - 1; k >= 0; k--) begin
			if (flags[k]) begin
				firstCode = 4'(k + 1);
			end
		end
	endfunction

	logic [25:0] tickCount_reg;
	logic secTick_reg;
	logic [11:0] volts [3];
	logic [11:0] amps [3];
	logic [11:0] voltSum;
	logic [11:0] nominal;
	logic [23:0] ovLimit;
	logic [23:0] uvStartLimit;
	logic [23:0] uvRunLimit;
	logic [23:0] ocLimit;
	logic [23:0] ucLimit;
	logic [23:0] imbLimit;
	logic [23:0] gfLimit;
	logic [23:0] vimbLimit;
	logic [MPT_NCHK-1:0] faultCond;
	logic [MPT_DLY_W-1:0] delays [MPT_NCHK];
	logic [MPT_NCHK-1:0] qualified;
	logic [MPT_NCHK-1:0] qualifiedFlags_reg;
	logic tripActive_reg;
	logic [3:0] faultCode_reg;
	mpt_run_state_t runState_reg;
	mpt_run_state_t runState_next;
	logic startPrev_reg;
	logic clearHold_reg;
	logic lockoutClearPulse_reg;
	logic lockoutBlocking_reg;
	logic lockoutRunning;
	logic startRise;

	// Seconds tick for all qualifying delays
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tickCount_reg <= '0;
			secTick_reg <= 1'b0;
		end else if (tickCount_reg == 26'(SECOND_CYCLES - 1)) begin
			tickCount_reg <= '0;
			secTick_reg <= 1'b1;
		end else begin
			tickCount_reg <= tickCount_reg + 1'b1;
			secTick_reg <= 1'b0;
		end
	end

	assign volts[0] = 12'(meas.lineVoltageAB);
	assign volts[1] = 12'(meas.lineVoltageBC);
	assign volts[2] = 12'(meas.lineVoltageCA);
	assign amps[0] = meas.currentA;
	assign amps[1] = meas.currentB;
	assign amps[2] = meas.currentC;
	assign voltSum = volts[0] + volts[1] + volts[2];
	assign nominal = 12'(settings.nominalLineVoltage);

	// Limits are kept times 100 so no division is needed
	assign ovLimit = mul(nominal, MPT_PCT_BASE + 12'(settings.overvoltageThreshold));
	assign uvStartLimit = mul(nominal,
		MPT_PCT_BASE - 12'(settings.startUndervoltageThreshold));
	assign uvRunLimit = mul(nominal,
		MPT_PCT_BASE - 12'(settings.runUndervoltageThreshold));
	assign ocLimit = mul(settings.motorFullLoadCurrent,
		12'(settings.overcurrentThreshold));
	assign ucLimit = mul(settings.motorFullLoadCurrent,
		12'(settings.undercurrentThreshold));
	assign imbLimit = mul(settings.motorFullLoadCurrent,
		12'(settings.currentImbalanceThreshold));
	assign gfLimit = mul(settings.currentTransformerValue,
		12'(settings.groundFaultThreshold));
	assign vimbLimit = mul(voltSum, 12'(settings.voltageImbalanceThreshold));

	// All checks evaluate every cycle side by side
	always_comb begin
		faultCond = '0;
		for (int p = 0; p < 3; p++) begin
			// Deviation from average, scaled by three to avoid division
			if (settings.voltageImbalanceThreshold != '0
				&& mul(absDiff(12'(3) * volts[p], voltSum), MPT_PCT_BASE) >= vimbLimit) begin
				faultCond[MPT_CHK_VIMB] = 1'b1;
			end
			if (settings.overvoltageThreshold != '0
				&& mul(volts[p], MPT_PCT_BASE) > ovLimit) begin
				faultCond[MPT_CHK_OV] = 1'b1;
			end
			if (settings.startUndervoltageThreshold != '0
				&& motorState == MPT_MOTOR_STARTING
				&& mul(volts[p], MPT_PCT_BASE) < uvStartLimit) begin
				faultCond[MPT_CHK_UVSTART] = 1'b1;
			end
			if (settings.runUndervoltageThreshold != '0
				&& motorState == MPT_MOTOR_AT_SPEED
				&& mul(volts[p], MPT_PCT_BASE) <= uvRunLimit) begin
				faultCond[MPT_CHK_UVRUN] = 1'b1;
			end
			if (motorState == MPT_MOTOR_OFF && amps[p] != '0) begin
				faultCond[MPT_CHK_SHUNT] = 1'b1;
			end
			if (settings.currentImbalanceThreshold != '0
				&& motorState != MPT_MOTOR_OFF
				&& mul(absDiff(amps[p], amps[(p + 1) % 3]), MPT_PCT_BASE) > imbLimit) begin
				faultCond[MPT_CHK_IIMB] = 1'b1;
			end
			if (settings.overcurrentThreshold != '0
				&& motorState == MPT_MOTOR_AT_SPEED
				&& mul(amps[p], MPT_PCT_BASE) > ocLimit) begin
				faultCond[MPT_CHK_OC] = 1'b1;
			end
			// Load loss only means something once running
			if (settings.undercurrentThreshold != '0
				&& motorState == MPT_MOTOR_AT_SPEED
				&& mul(amps[p], MPT_PCT_BASE) < ucLimit) begin
				faultCond[MPT_CHK_UC] = 1'b1;
			end
		end
		faultCond[MPT_CHK_SHORTED] = shortedThyristorDetected;
		if (settings.groundFaultThreshold != '0
			&& mul(meas.groundCurrent, MPT_PCT_BASE) > gfLimit) begin
			faultCond[MPT_CHK_GF] = 1'b1;
		end
	end

	assign delays[MPT_CHK_VIMB] = settings.voltageImbalanceDelay;
	assign delays[MPT_CHK_OV] = settings.overvoltageDelay;
	assign delays[MPT_CHK_UVSTART] = settings.startUndervoltageDelay;
	assign delays[MPT_CHK_UVRUN] = settings.runUndervoltageDelay;
	assign delays[MPT_CHK_SHORTED] = settings.shortedThyristorDelay;
	assign delays[MPT_CHK_SHUNT] = settings.offStateCurrentDelay;
	assign delays[MPT_CHK_IIMB] = settings.currentImbalanceDelay;
	assign delays[MPT_CHK_OC] = settings.overcurrentDelay;
	assign delays[MPT_CHK_UC] = settings.undercurrentDelay;
	assign delays[MPT_CHK_GF] = settings.groundFaultDelay;

	// A zero delay disables the slot inside the timer
	for (genvar g = 0; g < MPT_NCHK; g++) begin : genQualify
		mpt_qualify_timer #(
			.DLY_W(MPT_DLY_W)
		) uTimer (
			.clk(clk),
			.reset(reset),
			.secTick(secTick_reg),
			.faultCond(faultCond[g]),
			.delaySec(delays[g]),
			.qualified(qualified[g])
		);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			qualifiedFlags_reg <= '0;
		end else begin
			qualifiedFlags_reg <= qualified;
		end
	end

	// First qualified slot latches; a new trip beats a same-cycle reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tripActive_reg <= 1'b0;
			faultCode_reg <= MPT_FAULT_NONE;
		end else if (!tripActive_reg && qualified != '0) begin
			tripActive_reg <= 1'b1;
			faultCode_reg <= firstCode(qualified);
		end else if (tripActive_reg && faultReset && qualified == '0) begin
			tripActive_reg <= 1'b0;
			faultCode_reg <= MPT_FAULT_NONE;
		end
	end

	// Remaining time lives in the battery-backed clock, not here
	assign lockoutRunning = lockoutRemainingSec != '0 && !clearHold_reg;

	// Masks lockouts until the clock store confirms they are zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clearHold_reg <= 1'b0;
			lockoutClearPulse_reg <= 1'b0;
		end else begin
			lockoutClearPulse_reg <= lockoutClearFunction;
			if (lockoutClearFunction) begin
				clearHold_reg <= 1'b1;
			end else if (lockoutRemainingSec == '0) begin
				clearHold_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lockoutBlocking_reg <= 1'b0;
			startPrev_reg <= 1'b0;
		end else begin
			lockoutBlocking_reg <= lockoutRunning;
			startPrev_reg <= startCmd;
		end
	end

	assign startRise = startCmd && !startPrev_reg;

	always_comb begin
		runState_next = runState_reg;
		case (runState_reg)
			MPT_RUN_IDLE: begin
				if (tripActive_reg || lockoutRunning || stopCmd) begin
					runState_next = MPT_RUN_IDLE;
				end else if (threeWireControl && startRise) begin
					runState_next = MPT_RUN_ON;
				end else if (!threeWireControl && startCmd) begin
					runState_next = MPT_RUN_ON;
				end
			end
			MPT_RUN_ON: begin
				if (tripActive_reg || stopCmd) begin
					runState_next = MPT_RUN_IDLE;
				end else if (!threeWireControl && !startCmd) begin
					runState_next = MPT_RUN_IDLE;
				end
			end
			default: begin
				runState_next = MPT_RUN_IDLE;
			end
		endcase
		// A fresh trip drops the output in the same edge it latches
		if (qualified != '0) begin
			runState_next = MPT_RUN_IDLE;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			runState_reg <= MPT_RUN_IDLE;
		end else begin
			runState_reg <= runState_next;
		end
	end

	assign runRequest = runState_reg == MPT_RUN_ON;
	assign tripActive = tripActive_reg;
	assign faultCode = faultCode_reg;
	assign qualifiedFlags = qualifiedFlags_reg;
	assign lockoutBlocking = lockoutBlocking_reg;
	assign lockoutClearPulse = lockoutClearPulse_reg;

endmodule

// ===== mpt_meas_model.sv
`timescale 1ns/1ps
module mpt_meas_model
	import mpt_pkg::*;
(
	input wire logic clk,
	input wire logic slowMode,
	input wire logic [9:0] vAB,
	input wire logic [9:0] vBC,
	input wire logic [9:0] vCA,
	input wire logic [11:0] iA,
	input wire logic [11:0] iB,
	input wire logic [11:0] iC,
	input wire logic [11:0] iG,
	output mpt_pkg::mpt_meas_t meas
);
	logic [1:0] phaseReg = 2'h0;
	// Slow mode refreshes one cycle in four, like a multiplexed converter
	always_ff @(posedge clk) begin
		phaseReg <= phaseReg + 2'h1;
		if (!slowMode || phaseReg == 2'h0) begin
			meas <= {vAB, vBC, vCA, iA, iB, iC, iG};
		end
	end
endmodule

// ===== mpt_trip_logic_sva.sv
`timescale 1ns/1ps
module mpt_trip_logic_sva
	import mpt_pkg::*;
#(
	parameter int SECOND_CYCLES = MPT_SECOND_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input mpt_pkg::mpt_settings_t settings,
	input mpt_pkg::mpt_motor_state_t motorState,
	input wire logic startCmd,
	input wire logic stopCmd,
	input wire logic threeWireControl,
	input wire logic faultReset,
	input wire logic lockoutClearFunction,
	input wire logic runRequest,
	input wire logic tripActive,
	input wire logic [3:0] faultCode,
	input wire logic [MPT_NCHK-1:0] qualifiedFlags,
	input wire logic lockoutBlocking,
	input wire logic lockoutClearPulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_trip_has_code: assert property (tripActive |-> faultCode != 4'h0 && faultCode <= 4'hA)
		else $error("trip without valid code");
	a_trip_holds_code: assert property (tripActive && !faultReset |=> tripActive && $stable(faultCode))
		else $error("trip or code changed without reset");
	a_trip_stops_run: assert property (tripActive |-> !runRequest)
		else $error("starter on while tripped");
	a_stop_drops_run: assert property (stopCmd |=> !runRequest)
		else $error("starter on after stop");
	a_no_start_edge: assert property (!runRequest && !startCmd |=> !runRequest)
		else $error("starter on without start");
	a_two_wire_follow: assert property (!threeWireControl && !startCmd |=> !runRequest)
		else $error("two-wire run without start held");
	a_clear_pulse: assert property (lockoutClearFunction |=> lockoutClearPulse)
		else $error("clear pulse missing");
	a_clear_unblocks: assert property (lockoutClearFunction |-> ##2 !lockoutBlocking)
		else $error("lockout still blocking after clear");
	a_flags_mean_trip: assert property (qualifiedFlags != '0 |-> tripActive)
		else $error("qualified slot without trip");
	a_oc_gated: assert property ($past(motorState, 2) != MPT_MOTOR_AT_SPEED
		&& $past(motorState) != MPT_MOTOR_AT_SPEED && motorState != MPT_MOTOR_AT_SPEED
		|-> !qualifiedFlags[MPT_CHK_OC])
		else $error("over-current qualified before at speed");
	a_shorted_disabled: assert property ($past(settings.shortedThyristorDelay) == 8'h00
		&& settings.shortedThyristorDelay == 8'h00 |=> !qualifiedFlags[MPT_CHK_SHORTED])
		else $error("disabled shorted thyristor check qualified");
	c_trip: cover property ($rose(tripActive));
	c_trip_clear: cover property ($fell(tripActive));
	c_three_wire_run: cover property ($rose(runRequest) && threeWireControl);
	c_lock_clear: cover property (lockoutClearPulse);
endmodule
bind mpt_trip_logic mpt_trip_logic_sva #(.SECOND_CYCLES(SECOND_CYCLES)) u_sva (
	.clk(clk), .reset(reset), .settings(settings), .motorState(motorState),
	.startCmd(startCmd), .stopCmd(stopCmd), .threeWireControl(threeWireControl),
	.faultReset(faultReset), .lockoutClearFunction(lockoutClearFunction),
	.runRequest(runRequest), .tripActive(tripActive), .faultCode(faultCode),
	.qualifiedFlags(qualifiedFlags), .lockoutBlocking(lockoutBlocking),
	.lockoutClearPulse(lockoutClearPulse));

// ===== mpt_trip_logic_bench.sv
`timescale 1ns/1ps
module mpt_trip_logic_bench;
	import mpt_pkg::*;
	localparam int SEC = 20;
	logic clk, reset, shorted, startCmd, stopCmd, threeWire, faultReset, clearFn, slowMeas;
	logic [11:0] lockSec;
	mpt_settings_t settings;
	mpt_meas_t meas;
	mpt_motor_state_t motorState;
	logic [9:0] vAB, vBC, vCA;
	logic [11:0] iA, iB, iC, iG;
	logic runRequest, tripActive, lockoutBlocking, lockoutClearPulse;
	logic [3:0] faultCode;
	logic [MPT_NCHK-1:0] qualifiedFlags;
	int n_errors = 0;
	int n_compared = 0;
	integer seed = 32'hfb08107a;
	logic [3:0] expQ[$];
	mpt_meas_model model (.clk(clk), .slowMode(slowMeas), .vAB(vAB), .vBC(vBC), .vCA(vCA),
		.iA(iA), .iB(iB), .iC(iC), .iG(iG), .meas(meas));
	mpt_trip_logic #(.SECOND_CYCLES(SEC)) dut (.clk(clk), .reset(reset), .settings(settings),
		.meas(meas), .motorState(motorState), .shortedThyristorDetected(shorted),
		.startCmd(startCmd), .stopCmd(stopCmd), .threeWireControl(threeWire),
		.faultReset(faultReset), .lockoutClearFunction(clearFn), .lockoutRemainingSec(lockSec),
		.runRequest(runRequest), .tripActive(tripActive), .faultCode(faultCode),
		.qualifiedFlags(qualifiedFlags), .lockoutBlocking(lockoutBlocking),
		.lockoutClearPulse(lockoutClearPulse));
	task automatic finish_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Sample after the edge's updates have landed
	task automatic peek(input int n);
		cyc(n);
		#1;
	endtask
	task automatic base();
		settings <= '0;
		settings.nominalLineVoltage <= 10'h190;
		settings.currentTransformerValue <= 12'h0FA;
		settings.motorFullLoadCurrent <= 12'h064;
	endtask
	task automatic healthy();
		vAB <= 10'h190 + 10'($random(seed) & 3);
		vBC <= 10'h190 + 10'($random(seed) & 3);
		vCA <= 10'h190;
		{iA, iB, iC, iG} <= '0;
		motorState <= MPT_MOTOR_OFF;
		shorted <= 1'b0;
		slowMeas <= 1'b0;
	endtask
	task automatic hold(input int n);
		peek(n);
		check(tripActive, 1'b0);
	endtask
	task automatic expect_trip(input int d, input logic [3:0] code);
		int k;
		expQ.push_back(code);
		peek(d * SEC - 3);
		check(tripActive, 1'b0);
		k = 0;
		while (tripActive !== 1'b1 && k < 2 * SEC + 8) begin
			peek(1);
			k++;
		end
		check(16'(qualifiedFlags), 16'h0001 << (code - 4'h1));
		check({tripActive, faultCode, runRequest}, {1'b1, expQ.pop_front(), 1'b0});
	endtask
	task automatic clear_fault();
		cyc(1);
		base();
		healthy();
		cyc(5);
		faultReset <= 1'b1;
		cyc(2);
		faultReset <= 1'b0;
		peek(2);
		check({tripActive, faultCode, runRequest}, 6'h00);
		cyc(1);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#400000;
		n_errors++;
		finish_test();
	end
	initial begin
		reset = 1'b1;
		{startCmd, stopCmd, threeWire, faultReset, clearFn} = '0;
		lockSec = 12'h000;
		base();
		healthy();
		cyc(12);
		reset <= 1'b0;
		peek(1);
		check({runRequest, tripActive, faultCode, qualifiedFlags}, 16'h0000);
		cyc(1);
		startCmd <= 1'b1;
		settings.overvoltageThreshold <= 8'h0A;
		settings.overvoltageDelay <= 8'h03;
		vAB <= 10'h1B8;
		hold(3 * SEC);
		check(runRequest, 1'b1);
		cyc(1);
		vAB <= 10'h1B9;
		cyc(2 * SEC + 5);
		vAB <= 10'h190;
		cyc(2);
		vAB <= 10'h1B9;
		expect_trip(3, 4'(MPT_CHK_OV + 1));
		cyc(1);
		startCmd <= 1'b0;
		clear_fault();
		settings.overvoltageThreshold <= 8'h0A;
		settings.overvoltageDelay <= 8'h04;
		settings.voltageImbalanceThreshold <= 8'h05;
		settings.voltageImbalanceDelay <= 8'h01;
		vAB <= 10'h1B9;
		expect_trip(1, 4'(MPT_CHK_VIMB + 1));
		clear_fault();
		settings.runUndervoltageThreshold <= 8'h0A;
		settings.runUndervoltageDelay <= 8'h01;
		motorState <= MPT_MOTOR_STARTING;
		{vAB, vBC, vCA} <= {3{10'h168}};
		hold(3 * SEC);
		cyc(1);
		motorState <= MPT_MOTOR_AT_SPEED;
		expect_trip(1, 4'(MPT_CHK_UVRUN + 1));
		clear_fault();
		settings.startUndervoltageThreshold <= 8'h0A;
		settings.startUndervoltageDelay <= 8'h01;
		motorState <= MPT_MOTOR_STARTING;
		{vAB, vBC, vCA} <= {3{10'h167}};
		expect_trip(1, 4'(MPT_CHK_UVSTART + 1));
		clear_fault();
		settings.overcurrentThreshold <= 9'h096;
		settings.overcurrentDelay <= 8'h01;
		motorState <= MPT_MOTOR_STARTING;
		{iA, iB, iC} <= {3{12'h0A0}};
		hold(3 * SEC);
		cyc(1);
		motorState <= MPT_MOTOR_AT_SPEED;
		expect_trip(1, 4'(MPT_CHK_OC + 1));
		clear_fault();
		settings.currentImbalanceThreshold <= 8'h0A;
		settings.currentImbalanceDelay <= 8'h01;
		motorState <= MPT_MOTOR_AT_SPEED;
		{iA, iB, iC} <= {12'h064, 12'h064, 12'h050};
		expect_trip(1, 4'(MPT_CHK_IIMB + 1));
		clear_fault();
		settings.undercurrentThreshold <= 8'h32;
		settings.undercurrentDelay <= 8'h01;
		motorState <= MPT_MOTOR_AT_SPEED;
		{iA, iB, iC} <= {3{12'h028}};
		expect_trip(1, 4'(MPT_CHK_UC + 1));
		clear_fault();
		settings.groundFaultThreshold <= 8'h14;
		settings.groundFaultDelay <= 8'h01;
		slowMeas <= 1'b1;
		iG <= 12'h032;
		hold(3 * SEC);
		cyc(1);
		iG <= 12'h033;
		expect_trip(1, 4'(MPT_CHK_GF + 1));
		clear_fault();
		shorted <= 1'b1;
		hold(3 * SEC);
		cyc(1);
		// Fresh detection so the delay is timed from zero
		shorted <= 1'b0;
		settings.shortedThyristorDelay <= 8'h01;
		cyc(1);
		shorted <= 1'b1;
		expect_trip(1, 4'(MPT_CHK_SHORTED + 1));
		clear_fault();
		settings.offStateCurrentDelay <= 8'h01;
		iA <= 12'h005;
		expect_trip(1, 4'(MPT_CHK_SHUNT + 1));
		clear_fault();
		threeWire <= 1'b1;
		lockSec <= 12'h005;
		cyc(3);
		startCmd <= 1'b1;
		peek(4);
		check({runRequest, lockoutBlocking}, 2'b01);
		cyc(1);
		lockSec <= 12'h000;
		peek(4);
		check(runRequest, 1'b0);
		cyc(1);
		startCmd <= 1'b0;
		cyc(2);
		startCmd <= 1'b1;
		peek(3);
		check(runRequest, 1'b1);
		cyc(1);
		stopCmd <= 1'b1;
		startCmd <= 1'b0;
		cyc(2);
		stopCmd <= 1'b0;
		threeWire <= 1'b0;
		lockSec <= 12'h005;
		startCmd <= 1'b1;
		peek(4);
		check({runRequest, lockoutBlocking}, 2'b01);
		cyc(1);
		lockSec <= 12'h000;
		peek(3);
		check(runRequest, 1'b1);
		cyc(1);
		startCmd <= 1'b0;
		lockSec <= 12'h005;
		cyc(3);
		clearFn <= 1'b1;
		cyc(1);
		clearFn <= 1'b0;
		#1;
		check(lockoutClearPulse, 1'b1);
		cyc(1);
		startCmd <= 1'b1;
		peek(3);
		check({runRequest, lockoutBlocking}, 2'b10);
		finish_test();
	end
endmodule
